// file: verilog/qud_consts.vh
// Constants for the quadrature up/down timer: offsets, fields, resets.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef QUD_CONSTS_VH
`define QUD_CONSTS_VH
// Register byte offsets
`define OFS_MODE      8'h00
`define OFS_CTRL      8'h04
`define OFS_IOCTL     8'h08
`define OFS_IRQEN     8'h0c
`define OFS_STAT      8'h10
`define OFS_CNT       8'h14
`define OFS_CMPA      8'h18
`define OFS_CMPB      8'h1c
`define OFS_CCE       8'h20
`define OFS_GATE      8'h24
`define OFS_IRQF      8'h28
`define ADDR_W        8
// Mode register fields
`define MD_START      0
`define MD_PHASE      1
`define MD_PWM        2
`define MD_EVCAP      3
`define MD_DFA        4
`define MD_DFB        5
`define MD_DFCK_LO    6
`define MD_DFCK_HI    7
// Control register fields
`define CR_CLR_LO     5
`define CR_CLR_HI     6
`define CLR_NONE      2'h0
`define CLR_A         2'h1
`define CLR_B         2'h2
// IO control: [2:0] channel a, [6:4] channel b
`define IO_A_LO       0
`define IO_A_HI       2
`define IO_B_LO       4
`define IO_B_HI       6
`define IO_B2         6
`define IO_CAP_RISE   3'h4
`define IO_CAP_FALL   3'h5
`define IO_CAP_BOTH   3'h6
`define IO_OUT_LOW    3'h1
`define IO_OUT_HIGH   3'h2
`define IO_OUT_TGL    3'h3
// Status and enable bit positions
`define ST_MATCH_A    0
`define ST_MATCH_B    1
`define ST_UDF        2
`define ST_OVF        3
`define ST_W          4
// Reset values
`define RST_8         8'h00
`define RST_16        16'h0000
`define RST_CCE       8'hff
`define CNT_MAX       16'hffff
`define CNT_ONE       16'h0001
// AXI responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
// Filter sampling: divider per clock select, taps
`define FLT_TAPS      3
`define DIV_W         5
`define DIV_1         5'h00
`define DIV_8         5'h07
`define DIV_32        5'h1f
`endif

// file: verilog/phase_decoder.v
// Phase decoder: edge and level classes of two phase inputs.
// Assumes inputs already synchronous to mclk; one count per cycle at most.
`include "qud_consts.vh"
module phase_decoder (
  input  wire       mclk,      // Timer clock
  input  wire       sys_rst,   // Async reset, high
  input  wire       clk_en,    // Freeze when low
  input  wire       pa,        // Phase input a
  input  wire       pb,        // Phase input b
  input  wire [7:0] cce,       // Count condition enables
  output wire       inc,       // Count up this cycle
  output wire       dec        // Count down this cycle
);
  reg pa_ff;                   // Previous a
  reg pb_ff;                   // Previous b
  wire a_r = pa & ~pa_ff;      // A rising
  wire a_f = ~pa & pa_ff;      // A falling
  wire b_r = pb & ~pb_ff;      // B rising
  wire b_f = ~pb & pb_ff;      // B falling
  wire [7:0] cond;             // Condition hits

  // Previous levels for edge detection
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
    end else if (clk_en) begin
      pa_ff <= pa;
      pb_ff <= pb;
    end
  end

  // Quadrature classes; level taken from the other pin's old value
  assign cond[7] = b_r & ~pa_ff;
  assign cond[6] = a_r &  pb_ff;
  assign cond[5] = b_f &  pa_ff;
  assign cond[4] = a_f & ~pb_ff;
  assign cond[3] = a_f &  pb_ff;
  assign cond[2] = b_f & ~pa_ff;
  assign cond[1] = a_r & ~pb_ff;
  assign cond[0] = b_r &  pa_ff;

  // Cleared enable bit blocks its condition
  wire [7:0] hit = cond & cce;
  // Both directions at once cancel (only on illegal inputs)
  assign inc = (|hit[7:4]) & ~(|hit[3:0]);
  assign dec = (|hit[3:0]) & ~(|hit[7:4]);
endmodule // phase_decoder

// file: verilog/quad_timer.v
// Quadrature up/down timer with AXI4-Lite registers.
// Assumes inputs synchronous to mclk; pins resolved outside from enables.
// What this block does
// - Count up/down on phase input edges
// - Phase mode ignores count source and edge
// - Clear source, io, irq, compares stay active
// - Eight enable bits: upper add, lower subtract
// - Phase mode bit selects phase counting
// - Start bit runs counter; counter accessible running or stopped while gate on
// - Capture, match, overflow, underflow raise flags
// - Channel a may pwm; channel b not
// - Four sources merge into one request
// - Request set when flag and enable
// - Flags clear only by software zero write
// - Edge detect delay after output to input
// - Gate off: writes ignored except to gate, reads zero (cce reads its reset value)
// - Event link capture on channel b
// - Mode write beats internal counter reset
// - Capture irq even while stopped
// - Overflow wraps to zero, sets flag
`include "qud_consts.vh"
module quad_timer (
  input  wire        mclk,          // Timer clock, 40 MHz
  input  wire        sys_rst,       // Async reset, high
  input  wire        clk_en,        // Freeze all state when low
  input  wire        phase_input_a, // Phase input a
  input  wire        phase_input_b, // Phase input b
  input  wire        pin_a_in,      // Channel pin a level
  input  wire        pin_b_in,      // Channel pin b level
  input  wire        event_in,      // Event link pulse
  output reg         pin_a_out,     // Channel pin a drive
  output reg         pin_b_out,     // Channel pin b drive
  output wire        irq,           // Combined request level
  input  wire [7:0]  s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output wire        s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output wire        s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [7:0]  s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output wire        s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read data valid
  input  wire        s_axi_rready   // Read data ready
);
  // Registers
  reg  [7:0]  mode_reg_ff;          // Start, phase, pwm, event, filter
  reg  [7:0]  ctrl_ff;              // Timer control, clear source
  reg  [7:0]  ioctl_ff;             // Channel io control
  reg  [3:0]  irqen_ff;             // Interrupt enables
  reg  [3:0]  stat_ff;              // Status flags
  reg  [15:0] cnt_ff;               // Up/down counter
  reg  [15:0] cmpa_ff;              // Compare/capture a
  reg  [15:0] cmpb_ff;              // Compare/capture b
  reg  [7:0]  cce_ff;               // Count condition enables
  reg         gate_ff;              // Peripheral clock gate
  reg         irqf_ff;              // Combined request flag
  // Bus state
  reg         aw_ff;                // Write address held
  reg         w_ff;                 // Write data held
  reg  [7:0]  awaddr_ff;            // Latched write address
  reg  [31:0] wdata_ff;             // Latched write data
  reg  [3:0]  wstrb_ff;             // Latched strobes
  // Pin edge detection and filter
  reg  [2:0]  flt_a_ff;             // Filter taps a
  reg  [2:0]  flt_b_ff;             // Filter taps b
  reg         pa_lvl_ff;            // Filtered level a
  reg         pb_lvl_ff;            // Filtered level b
  reg         pa_old_ff;            // Previous level a
  reg         pb_old_ff;            // Previous level b
  reg  [4:0]  div_ff;               // Filter sample divider

  wire running  = mode_reg_ff[`MD_START];
  wire phase_md = mode_reg_ff[`MD_PHASE];
  wire pwm_md   = mode_reg_ff[`MD_PWM];
  wire [2:0] io_a = ioctl_ff[`IO_A_HI:`IO_A_LO];
  wire [2:0] io_b = ioctl_ff[`IO_B_HI:`IO_B_LO];
  wire [1:0] clr_sel = ctrl_ff[`CR_CLR_HI:`CR_CLR_LO];

  // Write handshake: take address and data in any order
  assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_go = aw_ff & w_ff & ~s_axi_bvalid;
  wire [7:0] wa = awaddr_ff;
  wire wr_mapped = (wa == `OFS_MODE) | (wa == `OFS_CTRL) |
                   (wa == `OFS_IOCTL) | (wa == `OFS_IRQEN) |
                   (wa == `OFS_STAT) | (wa == `OFS_CNT) |
                   (wa == `OFS_CMPA) | (wa == `OFS_CMPB) |
                   (wa == `OFS_CCE) | (wa == `OFS_GATE) |
                   (wa == `OFS_IRQF);
  // Gate off blocks every timer write but the gate itself
  wire wr_ok = wr_go & (gate_ff | (wa == `OFS_GATE));
  wire wr_lo = wstrb_ff[0];
  wire wr_hi = wstrb_ff[1];
  wire we_mode  = wr_ok & wr_lo & (wa == `OFS_MODE);
  wire we_ctrl  = wr_ok & wr_lo & (wa == `OFS_CTRL);
  wire we_ioctl = wr_ok & wr_lo & (wa == `OFS_IOCTL);
  wire we_irqen = wr_ok & wr_lo & (wa == `OFS_IRQEN);
  wire we_stat  = wr_ok & wr_lo & (wa == `OFS_STAT);
  wire we_cce   = wr_ok & wr_lo & (wa == `OFS_CCE);
  wire we_gate  = wr_ok & wr_lo & (wa == `OFS_GATE);
  wire we_irqf  = wr_ok & wr_lo & (wa == `OFS_IRQF);
  wire hit_cnt  = wr_ok & (wa == `OFS_CNT);
  wire hit_cmpa = wr_ok & (wa == `OFS_CMPA);
  wire hit_cmpb = wr_ok & (wa == `OFS_CMPB);

  // Bus write side and response
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      awaddr_ff    <= `RST_8;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; gate off reads zero, except cce (reset value) and gate
  reg [31:0] rd_val;
  reg        rd_map;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_map = 1'b1;
    case (s_axi_araddr)
      `OFS_MODE:  rd_val[7:0]  = mode_reg_ff;
      `OFS_CTRL:  rd_val[7:0]  = ctrl_ff;
      `OFS_IOCTL: rd_val[7:0]  = ioctl_ff;
      `OFS_IRQEN: rd_val[3:0]  = irqen_ff;
      `OFS_STAT:  rd_val[3:0]  = stat_ff;
      `OFS_CNT:   rd_val[15:0] = cnt_ff;
      `OFS_CMPA:  rd_val[15:0] = cmpa_ff;
      `OFS_CMPB:  rd_val[15:0] = cmpb_ff;
      `OFS_CCE:   rd_val[7:0]  = cce_ff;
      `OFS_GATE:  rd_val[0]    = gate_ff;
      `OFS_IRQF:  rd_val[0]    = irqf_ff;
      default:    rd_map       = 1'b0;        // Unmapped
    endcase
  end

  // Read channel: one cycle latency
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
        if (gate_ff | (s_axi_araddr == `OFS_GATE))
          s_axi_rdata <= rd_val;
        else if (s_axi_araddr == `OFS_CCE)
          s_axi_rdata <= {24'h000000, `RST_CCE};
        else
          s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Phase decode; count source and edge select not consulted here
  wire q_inc;
  wire q_dec;
  phase_decoder u_dec (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .pa      (phase_input_a),
    .pb      (phase_input_b),
    .cce     (cce_ff),
    .inc     (q_inc),
    .dec     (q_dec)
  );
  // Phase mode alone drives counting; no internal source modelled
  wire cnt_up = running & phase_md & gate_ff & q_inc;
  wire cnt_dn = running & phase_md & gate_ff & q_dec;

  // Filter sample strobe from clock select; three equal taps pass
  reg [4:0] div_top;
  always @* begin
    case (mode_reg_ff[`MD_DFCK_HI:`MD_DFCK_LO])
      2'h0:    div_top = `DIV_1;
      2'h1:    div_top = `DIV_8;
      2'h2:    div_top = `DIV_32;
      default: div_top = `DIV_1;
    endcase
  end
  wire smp = (div_ff >= div_top);

  // Capture pin levels; filter settles after three equal samples
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff    <= 5'h00;
      flt_a_ff  <= 3'h0;
      flt_b_ff  <= 3'h0;
      pa_lvl_ff <= 1'b0;
      pb_lvl_ff <= 1'b0;
      pa_old_ff <= 1'b0;
      pb_old_ff <= 1'b0;
    end else if (clk_en) begin
      div_ff <= smp ? 5'h00 : div_ff + 5'h01;
      if (smp) begin
        flt_a_ff <= {flt_a_ff[1:0], pin_a_in};
        flt_b_ff <= {flt_b_ff[1:0], pin_b_in};
      end
      if (!mode_reg_ff[`MD_DFA])
        pa_lvl_ff <= pin_a_in;
      else if (flt_a_ff == 3'h7 || flt_a_ff == 3'h0)
        pa_lvl_ff <= flt_a_ff[0];
      if (!mode_reg_ff[`MD_DFB])
        pb_lvl_ff <= pin_b_in;
      else if (flt_b_ff == 3'h7 || flt_b_ff == 3'h0)
        pb_lvl_ff <= flt_b_ff[0];
      pa_old_ff <= pa_lvl_ff;
      pb_old_ff <= pb_lvl_ff;
    end
  end

  // Capture edge select per channel
  function edge_ok;
    input [2:0] sel;
    input       now;
    input       old;
    begin
      case (sel)
        `IO_CAP_RISE: edge_ok = now & ~old;
        `IO_CAP_FALL: edge_ok = ~now & old;
        `IO_CAP_BOTH: edge_ok = now ^ old;
        default:      edge_ok = 1'b0;
      endcase
    end
  endfunction
  // Captures ignore the start bit
  wire cap_a = ~pwm_md & edge_ok(io_a, pa_lvl_ff, pa_old_ff);
  // Event link needs rising capture on b, not in pwm
  wire ev_cap = mode_reg_ff[`MD_EVCAP] & (io_b == `IO_CAP_RISE) &
                ~pwm_md & event_in;
  wire cap_b = edge_ok(io_b, pb_lvl_ff, pb_old_ff) | ev_cap;
  wire a_is_cap = io_a[`IO_A_HI] & ~pwm_md;
  wire b_is_cap = io_b[2];

  // Compare matches are live in phase mode too
  wire m_a = running & ~a_is_cap & (cnt_ff == cmpa_ff);
  wire m_b = running & ~b_is_cap & (cnt_ff == cmpb_ff);
  wire clr_hit = ((clr_sel == `CLR_A) & (m_a | cap_a)) |
                 ((clr_sel == `CLR_B) & (m_b | cap_b));
  wire ovf = (cnt_up & (cnt_ff == `CNT_MAX)) |
             (clr_hit & (cnt_ff == `CNT_MAX));
  wire underflow_flag = cnt_dn & (cnt_ff == `RST_16);

  // Counter, captures and compares
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff  <= `RST_16;
      cmpa_ff <= `CNT_MAX;
      cmpb_ff <= `CNT_MAX;
    end else if (clk_en) begin
      if (hit_cnt) begin
        if (wr_lo) cnt_ff[7:0]  <= wdata_ff[7:0];
        if (wr_hi) cnt_ff[15:8] <= wdata_ff[15:8];
      end else if (clr_hit & ~we_mode)
        cnt_ff <= `RST_16;
      else if (cnt_up)
        cnt_ff <= cnt_ff + `CNT_ONE;
      else if (cnt_dn)
        cnt_ff <= cnt_ff - `CNT_ONE;
      if (hit_cmpa) begin
        if (wr_lo) cmpa_ff[7:0]  <= wdata_ff[7:0];
        if (wr_hi) cmpa_ff[15:8] <= wdata_ff[15:8];
      end else if (a_is_cap & cap_a)
        cmpa_ff <= cnt_ff;
      if (hit_cmpb) begin
        if (wr_lo) cmpb_ff[7:0]  <= wdata_ff[7:0];
        if (wr_hi) cmpb_ff[15:8] <= wdata_ff[15:8];
      end else if (b_is_cap & cap_b)
        cmpb_ff <= cnt_ff;
    end
  end

  // Status events; set wins over software zero write
  wire [3:0] ev;
  assign ev[`ST_MATCH_A] = m_a | (a_is_cap & cap_a);
  assign ev[`ST_MATCH_B] = m_b | (b_is_cap & cap_b);
  assign ev[`ST_UDF]     = underflow_flag;
  assign ev[`ST_OVF]     = ovf;
  wire [3:0] keep = we_stat ? (stat_ff & wdata_ff[3:0]) : stat_ff;
  wire [3:0] nxt_stat = keep | ev;
  wire any_src = |(nxt_stat & irqen_ff);

  // Settings, flags, combined request
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg_ff <= `RST_8;
      ctrl_ff     <= `RST_8;
      ioctl_ff    <= `RST_8;
      irqen_ff    <= 4'h0;
      stat_ff     <= 4'h0;
      cce_ff      <= `RST_CCE;
      gate_ff     <= 1'b0;
      irqf_ff     <= 1'b0;
    end else if (clk_en) begin
      if (we_mode)  mode_reg_ff <= wdata_ff[7:0];
      if (we_ctrl)  ctrl_ff     <= wdata_ff[7:0];
      if (we_ioctl) ioctl_ff    <= wdata_ff[7:0];
      if (we_irqen) irqen_ff    <= wdata_ff[3:0];
      if (we_cce)   cce_ff      <= wdata_ff[7:0];
      if (we_gate)  gate_ff     <= wdata_ff[0];
      stat_ff <= nxt_stat;
      // Request follows rising of the masked or; software clears it
      if (any_src & ~(|(stat_ff & irqen_ff)))
        irqf_ff <= 1'b1;
      else if (we_irqf & ~wdata_ff[0])
        irqf_ff <= 1'b0;
    end
  end
  assign irq = irqf_ff;

  // Compare outputs; channel a may carry pwm, channel b never
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_a_out <= 1'b0;
      pin_b_out <= 1'b0;
    end else if (clk_en) begin
      if (pwm_md) begin
        if (!running)
          pin_a_out <= (clr_sel != `CLR_B);
        else if (m_a & ~m_b)
          pin_a_out <= 1'b1;
        else if (m_b & ~m_a)
          pin_a_out <= 1'b0;
      end else if (we_ioctl) begin
        pin_a_out <= (wdata_ff[`IO_A_HI:`IO_A_LO] == `IO_OUT_HIGH);
      end else if (m_a) begin
        case (io_a)
          `IO_OUT_LOW:  pin_a_out <= 1'b0;
          `IO_OUT_HIGH: pin_a_out <= 1'b1;
          `IO_OUT_TGL:  pin_a_out <= ~pin_a_out;
          default:      pin_a_out <= pin_a_out;
        endcase
      end
      if (we_ioctl)
        pin_b_out <= (wdata_ff[`IO_B_HI:`IO_B_LO] == `IO_OUT_HIGH);
      else if (m_b) begin
        case (io_b)
          `IO_OUT_LOW:  pin_b_out <= 1'b0;
          `IO_OUT_HIGH: pin_b_out <= 1'b1;
          `IO_OUT_TGL:  pin_b_out <= ~pin_b_out;
          default:      pin_b_out <= pin_b_out;
        endcase
      end
    end
  end
endmodule // quad_timer

// file: dv/quad_timer_sva.sv
// Checker for quad_timer: bus answers and request clearing.
// Assumes it is bound to quad_timer and sees only its ports.
module quad_timer_sva (
  input wire        mclk,          // Timer clock
  input wire        sys_rst,       // Async reset, high
  input wire        irq,           // Combined request
  input wire        s_axi_awvalid, // Write address valid
  input wire        s_axi_awready, // Write address ready
  input wire        s_axi_wvalid,  // Write data valid
  input wire        s_axi_wready,  // Write data ready
  input wire        s_axi_bvalid,  // Write response valid
  input wire        s_axi_arvalid, // Read address valid
  input wire        s_axi_arready, // Read address ready
  input wire [31:0] s_axi_rdata,   // Read data
  input wire        s_axi_rvalid,  // Read data valid
  input wire        s_axi_rready   // Read data ready
);
  // One domain, so one clock and reset for all
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  read_cause_a: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("read without ask");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while busy");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  write_cause_a: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready, 2) ||
    $past(s_axi_wvalid && s_axi_wready, 2)) else $error("stray response");
  w_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  irq_clear_a: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("request dropped without a write");
endmodule // quad_timer_sva
bind quad_timer quad_timer_sva sva_i (.mclk, .sys_rst, .irq, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// file: dv/quad_encoder_model.sv
// Quadrature encoder model: one quarter step per go pulse.
// Assumes the bench leaves several cycles between go pulses.
module quad_encoder_model (
  input  wire mclk,    // Timer clock
  input  wire go,      // Take one quarter step
  input  wire dir,     // Low forward, high reverse
  output reg  phase_a, // Phase line a
  output reg  phase_b  // Phase line b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial phase_a = 1'b0;
  initial phase_b = 1'b0;
  // Gray step: only one line moves, so overlap is never lost
  always @(posedge mclk) begin
    if (go && (dir ^ phase_a ^ phase_b))
      phase_a <= ~phase_a;
    else if (go)
      phase_b <= ~phase_b;
  end
endmodule // quad_encoder_model

// file: dv/quadrature_updown_timer_tb_top.sv
// Bench for quad_timer: AXI4-Lite tasks and encoder step sequences.
// Assumes quad_encoder_model and the bound checker are compiled first.
`include "qud_consts.vh"
module quadrature_updown_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, sys_rst = 1;     // Clock, reset
  logic        go = 0, dir = 0;           // Encoder step controls
  wire         pa, pb, irq;               // Phase lines, request
  wire         pao, pbo;                  // Channel pin drives
  logic [7:0]  awaddr = 0, araddr = 0;    // Bus addresses
  logic [31:0] wdata = 0;                 // Write data
  logic [3:0]  wstrb = 4'hf;              // Full word writes only
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;              // Responses
  wire  [31:0] rdata;                     // Read data
  int          n_mismatch = 0, check_count = 0;
  always #12.5 mclk = ~mclk;
  quad_encoder_model enc (.mclk(mclk), .go(go), .dir(dir), .phase_a(pa),
    .phase_b(pb));
  quad_timer dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .phase_input_a(pa), .phase_input_b(pb), .pin_a_in(1'b0),
    .pin_b_in(1'b0), .event_in(1'b0), .pin_a_out(pao), .pin_b_out(pbo),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Compare and count
  task automatic chk(input [31:0] seen, input [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write one word; address and data offered together
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er}, "bresp");
  endtask
  // Read one word; rready comes late to stall the answer
  task automatic rdchk(input [7:0] a, input [31:0] exp, input string nm);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n == 2) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 50);
    rready <= 1'b0;
    chk(rvalid ? rdata : ~exp, exp, nm);
  endtask
  // Quarter steps, each level held well over three cycles
  task automatic step(input logic d, input int k);
    repeat (k) begin
      @(posedge mclk);
      go <= 1'b1;
      dir <= d;
      @(posedge mclk);
      go <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk(`OFS_CCE, 32'hff, "cce");
    wr(`OFS_CNT, 32'h1234);
    rdchk(`OFS_CNT, 32'h0, "cnt gated");
    wr(8'h3c, 32'h1, `RESP_SLVERR);
    wr(`OFS_GATE, 32'h1);
    rdchk(`OFS_CMPB, 32'hffff, "cmpb");
    wr(`OFS_IRQF, 32'h0);
    // Each condition bit alone over one full turn each way
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_MODE, 32'h2);
      wr(`OFS_CCE, 32'h1 << i);
      wr(`OFS_CNT, 32'h0);
      wr(`OFS_MODE, 32'h3);
      step(1'b0, 4);
      step(1'b1, 4);
      rdchk(`OFS_CNT, i > 3 ? 32'h1 : 32'hffff, "cnt bit");
    end
    rdchk(`OFS_STAT, 32'h7, "stat");
    // Overflow raises the request; flags stay until cleared
    wr(`OFS_IRQEN, 32'h0);
    wr(`OFS_STAT, 32'h0);
    wr(`OFS_IRQF, 32'h0);
    wr(`OFS_MODE, 32'h2);
    wr(`OFS_CCE, 32'hff);
    wr(`OFS_CNT, 32'hfffe);
    wr(`OFS_IRQEN, 32'h8);
    wr(`OFS_MODE, 32'h3);
    step(1'b0, 2);
    chk({31'h0, irq}, 32'h1, "irq");
    rdchk(`OFS_CNT, 32'h0, "cnt wrap");
    rdchk(`OFS_STAT, 32'hb, "stat ovf");
    step(1'b1, 1);
    rdchk(`OFS_CNT, 32'hffff, "cnt under");
    chk({31'h0, irq}, 32'h1, "irq held");
    wr(`OFS_IRQEN, 32'h0);
    wr(`OFS_STAT, 32'h0);
    wr(`OFS_IRQF, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq clear");
    // Stopped counter ignores phase edges
    wr(`OFS_MODE, 32'h2);
    step(1'b0, 3);
    rdchk(`OFS_CNT, 32'hffff, "cnt stop");
    // Outputs set up while stopped, then count started
    wr(`OFS_IOCTL, 32'h21);
    wr(`OFS_MODE, 32'h3);
    chk({30'h0, pao, pbo}, 32'h1, "pins");
    final_report;
  end
  // Watchdog far beyond the expected run
  initial begin
    #500000;
    n_mismatch++;
    final_report;
  end
endmodule // quadrature_updown_timer_tb_top
